// ---- oau_pkg.sv ----
// Package of constants and types for the operand addressing unit
package oau_pkg;
  localparam int DW = 8;
  // Addressing modes
  typedef enum logic [5:0] {
    OAU_M_SRC_IMM  = 6'h01,
    OAU_M_SRC_DIR  = 6'h02,
    OAU_M_SRC_IDX  = 6'h04,
    OAU_M_DST_DIR  = 6'h08,
    OAU_M_DST_IDX  = 6'h10,
    OAU_M_DST_IMM  = 6'h20
  } oau_mode_type;
  // Operations
  typedef enum logic [2:0] {
    OAU_OP_COPY = 3'h0,
    OAU_OP_ADD  = 3'h1,
    OAU_OP_AND  = 3'h2,
    OAU_OP_OR   = 3'h3,
    OAU_OP_XOR  = 3'h4
  } oau_op_type;
  // Register targets
  typedef enum logic [1:0] {
    OAU_R_ACC = 2'h0,
    OAU_R_FLG = 2'h1,
    OAU_R_STK = 2'h2,
    OAU_R_IDX = 2'h3
  } oau_reg_type;
  // Opcode fields: [7:5] op, [4:2] mode index, [1:0] register, space bit 0
  localparam int OPC_OP_HI   = 7;
  localparam int OPC_OP_LO   = 5;
  localparam int OPC_MD_HI   = 4;
  localparam int OPC_MD_LO   = 2;
  localparam int OPC_REG_HI  = 1;
  localparam int OPC_REG_LO  = 0;
  localparam int OPC_SPACE   = 0;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] FLG_CARRY = 8'h04;
  localparam logic [7:0] FLG_ZERO  = 8'h02;
  // Fetch states
  typedef enum logic [4:0] {
    OAU_S_OPC  = 5'h01,
    OAU_S_OP1  = 5'h02,
    OAU_S_OP2  = 5'h04,
    OAU_S_RD   = 5'h08,
    OAU_S_EXE  = 5'h10
  } oau_state_type;
endpackage

// ---- oau_ram.sv ----
// Data memory of 256 bytes with registered read data
`timescale 1ns/1ps
`default_nettype none
module oau_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          CLK,
  input  wire logic [AW-1:0] waddr,
  input  wire logic          we,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge CLK) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // oau_ram
`default_nettype wire

// ---- oau_regspace.sv ----
// Register-space model answering the unit's reads and writes
`timescale 1ns/1ps
`default_nettype none
module oau_regspace (
  input  wire logic       CLK,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_RD,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  output var  logic [7:0] REG_RDATA
);
  logic [7:0] mem [256];
  // Answers in the cycle the strobe stands; without the strobe the
  // inverse shows, so a read the unit never asked for cannot match
  assign REG_RDATA = REG_RD ? mem[REG_ADDR] : ~mem[REG_ADDR];
  // Plain always so the bench may preload cells
  always @(posedge CLK) begin
    if (REG_WR) mem[REG_ADDR] <= REG_WDATA;
  end
endmodule // oau_regspace
`default_nettype wire

// ---- oau_unit.sv ----
// Operand addressing unit: decode, effective address, register writeback
// Function
// - Source-immediate writes acc, flags, stack top or index per opcode.
// - Source-immediate is two bytes; arithmetic uses the target as well.
// - An immediate AND aimed at the flag register ANDs into the flags.
// - Source-direct reads at the operand; acc or index is target and source.
// - Source-indexed reads at operand plus index into acc or index.
// - Opcode picks register space or RAM; register space returns a register.
// - Destination-direct stores acc or index at the operand, reading it too.
// - Destination-indexed stores acc at operand plus index, reading it too.
// - Destination modes never change the accumulator.
// - Destination-direct immediate is three bytes and stores the result.
// - The index register is eight bits wide and feeds every indexed address.
`timescale 1ns/1ps
`default_nettype none
module oau_unit
  import oau_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  input  wire logic          CODE_VALID,
  input  wire logic [DW-1:0] CODE_BYTE,
  input  wire logic [DW-1:0] REG_RDATA,
  output var  logic          CODE_TAKE,
  output var  logic [DW-1:0] REG_ADDR,
  output var  logic          REG_RD,
  output var  logic          REG_WR,
  output var  logic [DW-1:0] REG_WDATA,
  output var  logic [DW-1:0] ACC,
  output var  logic [DW-1:0] IDX,
  output var  logic [DW-1:0] FLG,
  output var  logic [DW-1:0] STACK_TOP_POINTER,
  output var  logic          DONE
);
  // Every check below runs on the core clock and sleeps through reset
  default clocking chk_clk @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  // ****************************************************************
  // Decode
  // ****************************************************************
  oau_state_type state;
  logic [DW-1:0] opc, op1, op2, addr, mem_rd;
  logic [1:0]    cnt;
  logic          ram_we;
  logic          is_reg_space;
  oau_mode_type  mode;
  oau_op_type    oper;
  oau_reg_type   rsel;

  function automatic oau_mode_type mode_of(input logic [2:0] m);
    case (m)
      3'h0:    mode_of = OAU_M_SRC_IMM;
      3'h1:    mode_of = OAU_M_SRC_DIR;
      3'h2:    mode_of = OAU_M_SRC_IDX;
      3'h3:    mode_of = OAU_M_DST_DIR;
      3'h4:    mode_of = OAU_M_DST_IDX;
      default: mode_of = OAU_M_DST_IMM;
    endcase
  endfunction

  function automatic logic [DW:0] alu(input oau_op_type o,
                                      input logic [DW-1:0] a,
                                      input logic [DW-1:0] b);
    case (o)
      OAU_OP_ADD: alu = {1'b0, a} + {1'b0, b};
      OAU_OP_AND: alu = {1'b0, a & b};
      OAU_OP_OR:  alu = {1'b0, a | b};
      OAU_OP_XOR: alu = {1'b0, a ^ b};
      default:    alu = {1'b0, b};
    endcase
  endfunction

  assign mode = mode_of(opc[OPC_MD_HI:OPC_MD_LO]);
  assign oper = oau_op_type'(opc[OPC_OP_HI:OPC_OP_LO]);
  assign rsel = oau_reg_type'(opc[OPC_REG_HI:OPC_REG_LO]);
  assign is_reg_space = opc[OPC_SPACE];

  // ****************************************************************
  // Operand gathering
  // ****************************************************************
  logic [DW-1:0] eff_addr;
  // Indexed address wraps within the 256 locations
  assign eff_addr = (mode == OAU_M_SRC_IDX || mode == OAU_M_DST_IDX)
                  ? DW'(op1 + IDX) : op1;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= OAU_S_OPC;
      opc   <= RST_BYTE;
      op1   <= RST_BYTE;
      op2   <= RST_BYTE;
      addr  <= RST_BYTE;
      cnt   <= 2'h0;
    end else begin
      case (state)
        OAU_S_OPC: if (CODE_VALID) begin
          opc   <= CODE_BYTE;
          state <= OAU_S_OP1;
        end
        OAU_S_OP1: if (CODE_VALID) begin
          op1 <= CODE_BYTE;
          // Three bytes only for destination direct with immediate
          if (mode == OAU_M_DST_IMM) begin
            cnt   <= LEN_THREE;
            state <= OAU_S_OP2;
          end else if (mode == OAU_M_SRC_IMM) begin
            cnt   <= LEN_TWO;
            state <= OAU_S_EXE;
          end else begin
            cnt   <= LEN_TWO;
            state <= OAU_S_RD;
          end
        end
        OAU_S_OP2: if (CODE_VALID) begin
          op2   <= CODE_BYTE;
          state <= OAU_S_RD;
        end
        OAU_S_RD: begin
          addr  <= eff_addr;
          state <= OAU_S_EXE;
        end
        OAU_S_EXE: state <= OAU_S_OPC;
        default:   state <= OAU_S_OPC;
      endcase
    end
  end

  // Read strobe and address stand in the execute cycle, so register
  // space must answer within that same cycle
  logic [DW-1:0] rd_data;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CODE_TAKE <= 1'b0;
      REG_RD    <= 1'b0;
      REG_ADDR  <= RST_BYTE;
    end else begin
      CODE_TAKE <= (state == OAU_S_OPC || state == OAU_S_OP1 ||
                    state == OAU_S_OP2) && CODE_VALID;
      REG_RD    <= (state == OAU_S_RD) && is_reg_space;
      if (state == OAU_S_RD) begin
        REG_ADDR <= eff_addr;
      end
    end
  end
  // Register space returns its register, not RAM
  assign rd_data = is_reg_space ? REG_RDATA : mem_rd;

  // ****************************************************************
  // Execute and writeback
  // ****************************************************************
  logic [DW:0]   res;
  logic [DW-1:0] dst_val, src_val;
  logic          exe, dst_mode;
  assign exe      = (state == OAU_S_EXE);
  assign dst_mode = (mode == OAU_M_DST_DIR || mode == OAU_M_DST_IDX ||
                     mode == OAU_M_DST_IMM);

  always_comb begin
    dst_val = ACC;
    src_val = op1;
    case (mode)
      OAU_M_SRC_IMM: begin
        case (rsel)
          OAU_R_ACC: dst_val = ACC;
          OAU_R_FLG: dst_val = FLG;
          OAU_R_STK: dst_val = STACK_TOP_POINTER;
          default:   dst_val = IDX;
        endcase
        src_val = op1;
      end
      OAU_M_SRC_DIR, OAU_M_SRC_IDX: begin
        dst_val = (rsel == OAU_R_IDX) ? IDX : ACC;
        src_val = rd_data;
      end
      OAU_M_DST_DIR: begin
        dst_val = rd_data;
        src_val = (rsel == OAU_R_IDX) ? IDX : ACC;
      end
      OAU_M_DST_IDX: begin
        dst_val = rd_data;
        src_val = ACC;
      end
      OAU_M_DST_IMM: begin
        dst_val = rd_data;
        src_val = op2;
      end
      default: begin
        dst_val = ACC;
        src_val = op1;
      end
    endcase
  end
  assign res    = alu(oper, dst_val, src_val);
  assign ram_we = exe && dst_mode && !is_reg_space;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ACC               <= RST_BYTE;
      IDX               <= RST_BYTE;
      FLG               <= RST_BYTE;
      STACK_TOP_POINTER <= RST_BYTE;
      REG_WR            <= 1'b0;
      REG_WDATA         <= RST_BYTE;
      DONE              <= 1'b0;
    end else begin
      REG_WR <= exe && dst_mode && is_reg_space;
      DONE   <= exe;
      if (exe && dst_mode) begin
        REG_WDATA <= res[DW-1:0]; // Accumulator left alone
      end
      if (exe && !dst_mode) begin
        if (mode == OAU_M_SRC_IMM && rsel == OAU_R_FLG) begin
          FLG <= res[DW-1:0];
        end else begin
          case (rsel)
            OAU_R_IDX: IDX <= res[DW-1:0];
            OAU_R_STK: if (mode == OAU_M_SRC_IMM) begin
              STACK_TOP_POINTER <= res[DW-1:0];
            end else begin
              ACC <= res[DW-1:0];
            end
            default:   ACC <= res[DW-1:0];
          endcase
          if (oper == OAU_OP_ADD) begin
            FLG <= (FLG & ~(FLG_CARRY | FLG_ZERO))
                 | (res[DW] ? FLG_CARRY : RST_BYTE)
                 | (res[DW-1:0] == RST_BYTE ? FLG_ZERO : RST_BYTE);
          end
        end
      end
    end
  end

  oau_ram #(.AW(DW), .DW(DW)) u_ram (
    .CLK   (CLK),
    .waddr (addr),
    .we    (ram_we),
    .wdata (res[DW-1:0]),
    .raddr (eff_addr),
    .rdata (mem_rd)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_dst_keeps_acc: assert property (
    (exe && dst_mode) |=> ACC == $past(ACC))
    else $error("accumulator changed in destination mode");
  chk_flag_and_imm: assert property (
    (exe && mode == OAU_M_SRC_IMM && rsel == OAU_R_FLG && oper == OAU_OP_AND)
    |=> FLG == ($past(FLG) & $past(op1)))
    else $error("flag AND immediate wrong");
  chk_idx_wrap: assert property (
    (state == OAU_S_RD && mode == OAU_M_DST_IDX)
    |=> REG_ADDR == DW'($past(op1) + $past(IDX)))
    else $error("indexed address wrong");
  chk_reg_write: assert property (
    (exe && dst_mode && is_reg_space)
    |=> REG_WR && REG_WDATA == $past(res[DW-1:0]))
    else $error("register-space write missing");
  chk_imm_len: assert property (
    (state == OAU_S_OP1 && CODE_VALID && mode == OAU_M_SRC_IMM) |=> exe)
    else $error("immediate not two bytes");
  chk_three_byte: assert property (
    (state == OAU_S_OP1 && CODE_VALID && mode == OAU_M_DST_IMM)
    |=> state == OAU_S_OP2)
    else $error("three-byte form not fetched");
  chk_fetch_len: assert property (
    exe |-> cnt == ((mode == OAU_M_DST_IMM) ? LEN_THREE : LEN_TWO))
    else $error("instruction length wrong");
endmodule // oau_unit
`default_nettype wire

// ---- operand_addressing_unit_bench.sv ----
// Self-checking bench for the operand addressing unit
`timescale 1ns/1ps
`default_nettype none
module operand_addressing_unit_bench;
  import oau_pkg::*;
  logic       clk;
  logic       rst;
  logic       code_valid;
  logic       code_take;
  logic       reg_rd;
  logic       reg_wr;
  logic       done;
  logic [7:0] code_byte;
  logic [7:0] reg_rdata;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] acc;
  logic [7:0] idx;
  logic [7:0] flg;
  logic [7:0] stk;
  int         miscompares = 0;
  int         checks_done = 0;

  oau_unit u_oau_unit (
    .CLK(clk), .SYS_RST(rst), .CODE_VALID(code_valid),
    .CODE_BYTE(code_byte), .REG_RDATA(reg_rdata),
    .CODE_TAKE(code_take), .REG_ADDR(reg_addr), .REG_RD(reg_rd),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .ACC(acc), .IDX(idx),
    .FLG(flg), .STACK_TOP_POINTER(stk), .DONE(done)
  );
  oau_regspace u_oau_regspace (
    .CLK(clk), .REG_ADDR(reg_addr), .REG_RD(reg_rd), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Feed one instruction byte by byte, then wait for completion
  task automatic exec(input logic [2:0] op, input logic [2:0] md,
                      input logic [1:0] rg, input logic [7:0] b1,
                      input logic [7:0] b2 = 8'h00);
    logic [7:0] b [3];
    int n;
    int k;
    int w;
    b = '{{op, md, rg}, b1, b2};
    n = (md == 3'h5) ? 3 : 2;
    k = 0;
    w = 0;
    code_valid = 1'b1;
    code_byte = b[0];
    while (k < n && w < 40) begin
      @(posedge clk);
      #1;
      w++;
      if (code_take === 1'b1) begin
        k++;
        if (k < n) code_byte = b[k];
      end
    end
    code_valid = 1'b0;
    while (done !== 1'b1 && w < 40) begin
      @(posedge clk);
      #1;
      w++;
    end
    check({7'h00, done}, 8'h01);
    // One more edge lets the far-side write land
    @(posedge clk);
    #1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_src_imm();
    check(acc | idx | flg | stk, 8'h00);
    exec(OAU_OP_COPY, 3'h0, 2'h0, 8'h10);
    check(acc, 8'h10);
    exec(OAU_OP_COPY, 3'h0, 2'h2, 8'h3C);
    check(stk, 8'h3C);
    exec(OAU_OP_COPY, 3'h0, 2'h3, 8'hF0);
    check(idx, 8'hF0);
    exec(OAU_OP_ADD, 3'h0, 2'h0, 8'h07);
    check(acc, 8'h17);
    exec(OAU_OP_OR, 3'h0, 2'h0, 8'h40);
    check(acc, 8'h57);
    exec(OAU_OP_XOR, 3'h0, 2'h0, 8'hFF);
    check(acc, 8'hA8);
    // A plain copy would leave 09, so only a true AND gives 08
    exec(OAU_OP_COPY, 3'h0, 2'h1, 8'h0C);
    exec(OAU_OP_AND, 3'h0, 2'h1, 8'h09);
    check(flg, 8'h08);
    $display("source immediate done");
  endtask

  task automatic t_src_space();
    exec(OAU_OP_COPY, 3'h1, 2'h3, 8'h08);
    check(idx, 8'h5A);
    exec(OAU_OP_COPY, 3'h2, 2'h3, 8'h08);
    check(idx, 8'h33);
    // 33 + E0 must wrap to 13
    exec(OAU_OP_ADD, 3'h2, 2'h3, 8'hE0);
    check(idx, 8'hAA);
    $display("source register space done");
  endtask

  task automatic t_dst();
    exec(OAU_OP_COPY, 3'h3, 2'h3, 8'h20);
    check(u_oau_regspace.mem[8'h20], 8'hAA);
    check(acc, 8'hA8);
    // AA + 70 wraps to 1A
    exec(OAU_OP_ADD, 3'h4, 2'h1, 8'h70);
    check(u_oau_regspace.mem[8'h1A], 8'hA9);
    check(acc, 8'hA8);
    $display("destination modes done");
  endtask

  task automatic t_ram();
    exec(OAU_OP_COPY, 3'h3, 2'h0, 8'h07);
    exec(OAU_OP_ADD, 3'h1, 2'h0, 8'h07);
    check(acc, 8'h50);
    check(u_oau_regspace.mem[8'h07], 8'h00);
    $display("ram space done");
  endtask

  task automatic t_dst_imm();
    exec(OAU_OP_COPY, 3'h5, 2'h1, 8'h30, 8'h66);
    check(u_oau_regspace.mem[8'h30], 8'h66);
    exec(OAU_OP_ADD, 3'h5, 2'h1, 8'h30, 8'h05);
    check(u_oau_regspace.mem[8'h30], 8'h6B);
    check(acc, 8'h50);
    $display("destination immediate done");
  endtask

  initial begin
    code_valid = 1'b0;
    code_byte = 8'h00;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    u_oau_regspace.mem[8'h08] = 8'h5A;
    u_oau_regspace.mem[8'h62] = 8'h33;
    u_oau_regspace.mem[8'h13] = 8'h77;
    u_oau_regspace.mem[8'h1A] = 8'h01;
    u_oau_regspace.mem[8'h07] = 8'h00;
    t_src_imm();
    t_src_space();
    t_dst();
    t_ram();
    t_dst_imm();
    final_report();
  end

  // About twenty instructions of four to six cycles fit well inside this
  initial begin
    #20000;
    miscompares++;
    final_report();
  end
endmodule // operand_addressing_unit_bench
`default_nettype wire
